// ---- src/ppmc_override_filter.sv ----
// Purpose: up/down counting filter for one external override input
// Assumes: input is synchronous to i_clk
// Notes:   settles once a solid level would have been decided
`timescale 1ns/1ps
module ppmc_override_filter #(
    parameter int FULL_CYC = 1000000
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    // control
    input  wire logic i_clear,
    input  wire logic i_level,
    // result
    output logic      o_enabled,
    output logic      o_settled
);
    import ppmc_pkg::*;

    localparam logic [CNT_W-1:0] FULL   = CNT_W'(FULL_CYC);
    localparam logic [CNT_W-1:0] ON_TH  = CNT_W'(FULL_CYC * DEG_ON_PCT / PCT_FULL);
    localparam logic [CNT_W-1:0] OFF_TH = CNT_W'(FULL_CYC * DEG_OFF_PCT / PCT_FULL);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] samp_reg;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_reg <= '0;
        end else if (i_clear) begin
            cnt_reg <= '0;
        end else if (i_level && cnt_reg < FULL) begin
            cnt_reg <= cnt_reg + 1'b1;
        end else if (!i_level && cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // hysteresis between the two thresholds rejects short glitches
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_enabled <= 1'b0;
        end else if (i_clear) begin
            o_enabled <= 1'b0;
        end else if (cnt_reg > ON_TH) begin
            o_enabled <= 1'b1;
        end else if (cnt_reg < OFF_TH) begin
            o_enabled <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            samp_reg  <= '0;
            o_settled <= 1'b0;
        end else if (i_clear) begin
            samp_reg  <= '0;
            o_settled <= 1'b0;
        end else if (samp_reg > ON_TH) begin
            o_settled <= 1'b1;
        end else begin
            samp_reg  <= samp_reg + 1'b1;
        end
    end

endmodule : ppmc_override_filter

// ---- src/ppmc_pkg.sv ----
// Purpose: shared constants for the protector power-mode sequencer
// Assumes: 100 MHz core clock, supply-threshold detectors deliver clean levels
// Notes:   times are kept in microseconds, counts are derived in the top module
package ppmc_pkg;

    localparam int          CLK_MHZ          = 100;
    localparam int          CNT_W            = 24;

    // power-up hold-off and override filter timing
    localparam int          HOLDOFF_US       = 5000;
    localparam int          DEG_SOLID_US     = 7000;
    localparam int          DEG_ON_PCT       = 70;
    localparam int          DEG_OFF_PCT      = 30;
    localparam int          PCT_FULL         = 100;

    // protection delays, plain defaults
    localparam int          FAULT_DELAY_US   = 1000;
    localparam int          REC_DELAY_US     = 100000;
    localparam int          OC_REC_US        = 100000;
    localparam int          TEST_ENTRY_US    = 1000;
    localparam int          TEST_DELAY_US    = 10;
    localparam int          TEST_OC_REC_US   = 10;

    // qualification instances
    localparam logic [1:0]  QUAL_NORMAL      = 2'h3;
    localparam logic [1:0]  QUAL_FAST        = 2'h1;

    // fixed factory charge over-temperature trip, in hundredths of a percent
    localparam logic [13:0] OTC_RATIO_BP     = 14'h0B7A;

    // protection channels
    localparam int          NUM_CH           = 4;
    localparam int          CH_OV            = 0;
    localparam int          CH_CHG           = 1;
    localparam int          CH_DSG           = 2;
    localparam int          CH_OC            = 3;
    localparam logic [3:0]  CH_RESET_FAULT   = 4'h1;

    typedef enum logic [2:0] {
        PPMC_WAIT_WAKE = 3'b000,
        PPMC_HOLDOFF   = 3'b001,
        PPMC_NORMAL    = 3'b010,
        PPMC_FAULT     = 3'b011,
        PPMC_SHUTDOWN  = 3'b100
    } ppmc_mode_t;

endpackage : ppmc_pkg

// ---- src/ppmc_power_mode_control.sv ----
// Purpose: power-mode sequencing and FET driver control of a pack protector
// Assumes: supply and cell comparators arrive as clean synchronous levels
// Notes:   long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
module ppmc_power_mode_control
    import ppmc_pkg::*;
#(
    parameter int HOLDOFF_CYC     = HOLDOFF_US * CLK_MHZ,
    parameter int DEG_FULL_CYC    = DEG_SOLID_US * CLK_MHZ * PCT_FULL / DEG_ON_PCT,
    parameter int FAULT_DELAY_CYC = FAULT_DELAY_US * CLK_MHZ,
    parameter int REC_DELAY_CYC   = REC_DELAY_US * CLK_MHZ,
    parameter int OC_REC_CYC      = OC_REC_US * CLK_MHZ,
    parameter int TEST_ENTRY_CYC  = TEST_ENTRY_US * CLK_MHZ
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // supply comparators
    input  wire logic        i_supply_above_wake,
    input  wire logic        i_supply_below_shut,
    input  wire logic        i_supply_above_test_margin,
    input  wire logic        i_supply_at_top_cell,
    // cell and fault comparators
    input  wire logic        i_ov_detect,
    input  wire logic        i_cell_above_ov_hys,
    input  wire logic        i_chg_fault_raw,
    input  wire logic        i_dsg_fault_raw,
    input  wire logic        i_oc_fault_raw,
    input  wire logic [13:0] i_thermistor_ratio_bp,
    // current-direction comparator
    input  wire logic        i_charge_current_seen,
    input  wire logic        i_discharge_current_seen,
    // override inputs
    input  wire logic        i_charge_override_in,
    input  wire logic        i_discharge_override_in,
    // drivers and status
    output logic             o_charge_fet_drive,
    output logic             o_discharge_fet_drive,
    output logic             o_state_comparator_en,
    output logic             o_fault_detect_en,
    output logic             o_fast_test_mode,
    output ppmc_pkg::ppmc_mode_t o_mode
);
    import ppmc_pkg::*;

    localparam logic [CNT_W-1:0] HOLDOFF_N   = CNT_W'(HOLDOFF_CYC);
    localparam logic [CNT_W-1:0] FAULT_N     = CNT_W'(FAULT_DELAY_CYC);
    localparam logic [CNT_W-1:0] REC_N       = CNT_W'(REC_DELAY_CYC);
    localparam logic [CNT_W-1:0] OC_REC_N    = CNT_W'(OC_REC_CYC);
    localparam logic [CNT_W-1:0] ENTRY_N     = CNT_W'(TEST_ENTRY_CYC);
    localparam logic [CNT_W-1:0] TEST_DLY_N  = CNT_W'(TEST_DELAY_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] TEST_OC_N   = CNT_W'(TEST_OC_REC_US * CLK_MHZ);

    ppmc_mode_t       mode_reg;
    ppmc_mode_t       mode_next;
    logic [CNT_W-1:0] hold_reg;
    logic [CNT_W-1:0] entry_reg;
    logic [CNT_W-1:0] exit_reg;
    logic             fast_reg;
    wire logic [NUM_CH-1:0] fault_reg;
    logic [NUM_CH-1:0] set_cond;
    logic [NUM_CH-1:0] clr_cond;
    logic             chg_en;
    logic             dsg_en;
    logic             chg_ok;
    logic             dsg_ok;
    logic             filt_clear;
    logic             hold_done;
    logic             otc_hot;
    logic             chg_off;
    logic             dsg_off;
    logic             run;

    ////////////////////////////////////////////////////////////////////////////
    // override filters, cleared in wait-wake so each power-up redoes the deglitch; a wake from shutdown does not
    assign filt_clear = (mode_reg == PPMC_WAIT_WAKE);

    ppmc_override_filter #(.FULL_CYC(DEG_FULL_CYC)) u_chg_filter (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_clear   (filt_clear),
        .i_level   (i_charge_override_in),
        .o_enabled (chg_en),
        .o_settled (chg_ok)
    );

    ppmc_override_filter #(.FULL_CYC(DEG_FULL_CYC)) u_dsg_filter (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_clear   (filt_clear),
        .i_level   (i_discharge_override_in),
        .o_enabled (dsg_en),
        .o_settled (dsg_ok)
    );

    ////////////////////////////////////////////////////////////////////////////
    // mode sequencing
    assign hold_done = (hold_reg >= HOLDOFF_N);
    assign run       = (mode_reg == PPMC_NORMAL) || (mode_reg == PPMC_FAULT);

    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            PPMC_WAIT_WAKE: begin
                if (i_supply_above_wake) mode_next = PPMC_HOLDOFF;
            end
            PPMC_HOLDOFF: begin
                if (hold_done && chg_ok && dsg_ok) mode_next = PPMC_NORMAL;
            end
            PPMC_NORMAL: begin
                if (|fault_reg) mode_next = PPMC_FAULT;
            end
            PPMC_FAULT: begin
                if (~|fault_reg) mode_next = PPMC_NORMAL;
            end
            PPMC_SHUTDOWN: begin
                if (i_supply_above_wake) mode_next = PPMC_NORMAL;
            end
            default: mode_next = PPMC_WAIT_WAKE;
        endcase
        if (i_supply_below_shut && mode_reg != PPMC_WAIT_WAKE) begin
            mode_next = PPMC_SHUTDOWN;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_reg <= PPMC_WAIT_WAKE;
        end else begin
            mode_reg <= mode_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hold_reg <= '0;
        end else if (mode_reg == PPMC_HOLDOFF && !hold_done) begin
            hold_reg <= hold_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fast test mode, entered and left by supply excursions
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            entry_reg <= '0;
            exit_reg  <= '0;
            fast_reg  <= 1'b0;
        end else if (!fast_reg) begin
            exit_reg  <= '0;
            if (!i_supply_above_test_margin) begin
                entry_reg <= '0;
            end else if (entry_reg + 1'b1 >= ENTRY_N) begin
                entry_reg <= '0;
                fast_reg  <= 1'b1;
            end else begin
                entry_reg <= entry_reg + 1'b1;
            end
        end else begin
            entry_reg <= '0;
            if (!i_supply_at_top_cell) begin
                exit_reg <= '0;
            end else if (exit_reg + 1'b1 >= ENTRY_N) begin
                exit_reg <= '0;
                fast_reg <= 1'b0;
            end else begin
                exit_reg <= exit_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // protection channels; set and clear conditions per fault type
    assign otc_hot = (i_thermistor_ratio_bp < OTC_RATIO_BP);

    assign set_cond[CH_OV]  = i_ov_detect;
    assign clr_cond[CH_OV]  = !i_cell_above_ov_hys;
    assign set_cond[CH_CHG] = i_chg_fault_raw || otc_hot;
    assign clr_cond[CH_CHG] = !set_cond[CH_CHG];
    assign set_cond[CH_DSG] = i_dsg_fault_raw;
    assign clr_cond[CH_DSG] = !i_dsg_fault_raw;
    assign set_cond[CH_OC]  = i_oc_fault_raw;
    assign clr_cond[CH_OC]  = !i_oc_fault_raw;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic [CNT_W-1:0] cnt_reg;
            logic [1:0]       inst_reg;
            logic [CNT_W-1:0] lim;
            logic [1:0]       need;
            logic             cond;
            logic             flag_reg;

            // recovery limits have their own constants for current faults in both delay sets; the test values are equal
            assign lim  = !fault_reg[ch] ? (fast_reg ? TEST_DLY_N : FAULT_N) :
                          (ch == CH_OC)  ? (fast_reg ? TEST_OC_N : OC_REC_N) :
                                           (fast_reg ? TEST_DLY_N : REC_N);
            assign need = fast_reg ? QUAL_FAST : QUAL_NORMAL;
            assign cond = fault_reg[ch] ? clr_cond[ch] : set_cond[ch];
            // one process per flag; the vector only gathers them
            assign fault_reg[ch] = flag_reg;

            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    cnt_reg       <= '0;
                    inst_reg      <= '0;
                    flag_reg      <= CH_RESET_FAULT[ch];
                end else if (mode_reg == PPMC_SHUTDOWN) begin
                    cnt_reg       <= '0;
                    inst_reg      <= '0;
                    flag_reg      <= 1'b0;
                end else if (!run) begin
                    // recovery of the power-up overvoltage waits for hold-off end
                    cnt_reg       <= '0;
                    inst_reg      <= '0;
                end else if (!cond) begin
                    cnt_reg       <= '0;
                    inst_reg      <= '0;
                end else if (cnt_reg + 1'b1 >= lim) begin
                    cnt_reg <= '0;
                    if (inst_reg + 1'b1 >= need) begin
                        inst_reg      <= '0;
                        flag_reg      <= !flag_reg;
                    end else begin
                        inst_reg <= inst_reg + 1'b1;
                    end
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // driver outputs; body-diode protection turns the blocked FET on
    assign chg_off = fault_reg[CH_OV] || fault_reg[CH_CHG];
    assign dsg_off = fault_reg[CH_DSG] || fault_reg[CH_OC];

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_charge_fet_drive    <= 1'b0;
            o_discharge_fet_drive <= 1'b0;
            o_state_comparator_en <= 1'b0;
        end else if (!run) begin
            o_charge_fet_drive    <= 1'b0;
            o_discharge_fet_drive <= 1'b0;
            o_state_comparator_en <= 1'b0;
        end else begin
            o_state_comparator_en <= (mode_reg == PPMC_FAULT) && (chg_off != dsg_off);
            o_charge_fet_drive    <= chg_en &&
                                     (!chg_off || (!dsg_off && i_discharge_current_seen));
            o_discharge_fet_drive <= dsg_en &&
                                     (!dsg_off || (!chg_off && i_charge_current_seen));
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fault_detect_en <= 1'b0;
            o_fast_test_mode  <= 1'b0;
            o_mode            <= PPMC_WAIT_WAKE;
        end else begin
            o_fault_detect_en <= run;
            o_fast_test_mode  <= fast_reg;
            o_mode            <= mode_reg;
        end
    end

endmodule : ppmc_power_mode_control

// ---- testbench/ppmc_pack_model.sv ----
// Purpose: pack side: current seen by the direction comparator
// Assumes: i_load_dir 0 idle, 1 charger attached, 2 load attached
// Notes:   an off FET still passes current one way through its body diode
`timescale 1ns/1ps
module ppmc_pack_model (
    // clock
    input  wire logic       i_clk,
    // driver levels and pack load
    input  wire logic       i_charge_fet_drive,
    input  wire logic       i_discharge_fet_drive,
    input  wire logic [1:0] i_load_dir,
    // direction comparator
    output logic            o_charge_current_seen,
    output logic            o_discharge_current_seen
);
    // charge needs the charge FET on, discharge the discharge FET on
    always @(posedge i_clk) begin
        o_charge_current_seen    <= (i_load_dir == 2'h1) && i_charge_fet_drive;
        o_discharge_current_seen <= (i_load_dir == 2'h2) && i_discharge_fet_drive;
    end
endmodule : ppmc_pack_model

// ---- testbench/ppmc_power_mode_control_properties.sv ----
// Purpose: port-level checks of the power-mode sequencer
// Assumes: counts handed on from the instance by the bind
// Notes:   o_mode lags the internal mode by one cycle
`timescale 1ns/1ps
module ppmc_checker
    import ppmc_pkg::*;
#(
    parameter int HOLDOFF_CYC    = 50,
    parameter int TEST_ENTRY_CYC = 8
) (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_reset_n,
    // supply levels
    input  wire logic                 i_supply_above_wake,
    input  wire logic                 i_supply_above_test_margin,
    input  wire logic                 i_supply_at_top_cell,
    // watched outputs
    input  wire logic                 o_charge_fet_drive,
    input  wire logic                 o_discharge_fet_drive,
    input  wire logic                 o_state_comparator_en,
    input  wire logic                 o_fault_detect_en,
    input  wire logic                 o_fast_test_mode,
    input  wire ppmc_pkg::ppmc_mode_t o_mode
);
    // wide enough for the unshortened hold-off and entry counts
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] marg_cnt;
    logic [CNT_W-1:0] top_cnt;
    ////////////////////////////////////////////////////////////
    // run lengths: hold-off and entry times exceed the repeat limit
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            hold_cnt <= '0;
        else
            hold_cnt <= (o_mode == PPMC_HOLDOFF) ? hold_cnt + 1'b1 : '0;
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            marg_cnt <= '0;
        else
            marg_cnt <= i_supply_above_test_margin ? marg_cnt + 1'b1 : '0;
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            top_cnt <= '0;
        else
            top_cnt <= i_supply_at_top_cell ? top_cnt + 1'b1 : '0;
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    AST_WAIT_OFF: assert property (
        o_mode == PPMC_WAIT_WAKE |-> !o_charge_fet_drive && !o_discharge_fet_drive)
        else $error("driver on before wake");
    AST_WAIT_HOLDS: assert property (
        o_mode == PPMC_WAIT_WAKE && !i_supply_above_wake && !$past(i_supply_above_wake)
        |-> ##2 o_mode == PPMC_WAIT_WAKE) else $error("left wait without wake");
    AST_HOLDOFF_OFF: assert property (
        o_mode == PPMC_HOLDOFF |-> !o_charge_fet_drive && !o_discharge_fet_drive)
        else $error("driver on during hold-off");
    AST_HOLDOFF_LEN: assert property (
        $fell(o_mode == PPMC_HOLDOFF) |-> hold_cnt >= HOLDOFF_CYC - 1)
        else $error("hold-off too short");
    AST_OV_PRESET: assert property (
        $fell(o_mode == PPMC_HOLDOFF) |-> !o_charge_fet_drive [*8])
        else $error("charge on right after hold-off");
    AST_COMP_FAULT: assert property (
        o_state_comparator_en |-> o_mode == PPMC_FAULT || $past(o_mode) == PPMC_FAULT)
        else $error("comparator on outside fault");
    AST_SHUT_OFF: assert property (
        o_mode == PPMC_SHUTDOWN && $past(o_mode) == PPMC_SHUTDOWN
        |-> !o_charge_fet_drive && !o_discharge_fet_drive) else $error("driver on in shutdown");
    AST_SHUT_NODET: assert property (
        o_mode == PPMC_SHUTDOWN && $past(o_mode) == PPMC_SHUTDOWN |-> !o_fault_detect_en)
        else $error("detection on in shutdown");
    AST_SHUT_WAKE: assert property (
        $fell(o_mode == PPMC_SHUTDOWN) |-> o_mode == PPMC_NORMAL)
        else $error("shutdown left to wrong mode");
    AST_RUN_DETECT: assert property (
        o_mode inside {PPMC_NORMAL, PPMC_FAULT} && $past(o_mode) inside {PPMC_NORMAL, PPMC_FAULT}
        |-> o_fault_detect_en) else $error("detection off in run mode");
    AST_TEST_IN: assert property (
        $rose(o_fast_test_mode) |-> marg_cnt >= TEST_ENTRY_CYC)
        else $error("test mode entered early");
    AST_TEST_OUT: assert property (
        $fell(o_fast_test_mode) |-> top_cnt >= TEST_ENTRY_CYC)
        else $error("test mode left early");
    COV_FAULT: cover property (o_mode == PPMC_FAULT && o_state_comparator_en);
    COV_SHUT: cover property ($fell(o_mode == PPMC_SHUTDOWN));
    COV_TEST: cover property ($fell(o_fast_test_mode));
endmodule : ppmc_checker

bind ppmc_power_mode_control ppmc_checker #(
    .HOLDOFF_CYC    (HOLDOFF_CYC),
    .TEST_ENTRY_CYC (TEST_ENTRY_CYC)
) u_checker (
    .i_clk, .i_reset_n, .i_supply_above_wake, .i_supply_above_test_margin,
    .i_supply_at_top_cell, .o_charge_fet_drive, .o_discharge_fet_drive,
    .o_state_comparator_en, .o_fault_detect_en, .o_fast_test_mode, .o_mode
);

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench of the power-mode sequencer
// Assumes: shortened counts; test delays fixed at 1000 cycles
// Notes:   outputs are read at the edge, before that edge's updates land
`timescale 1ns/1ps
module testbench;
    import ppmc_pkg::*;
    localparam int HO = 50;
    localparam int FD = 4;
    localparam int RD = 10;
    localparam int OCR = 12;
    localparam int TE = 8;
    localparam int TD = 1000;
    logic i_clk = 1'b0, i_reset_n, i_supply_above_wake, i_supply_below_shut;
    logic i_supply_above_test_margin, i_supply_at_top_cell, i_ov_detect, i_cell_above_ov_hys;
    logic i_chg_fault_raw, i_dsg_fault_raw, i_oc_fault_raw;
    logic i_charge_override_in, i_discharge_override_in;
    logic [13:0] i_thermistor_ratio_bp;
    logic [1:0] load_dir;
    logic i_charge_current_seen, i_discharge_current_seen;
    logic o_charge_fet_drive, o_discharge_fet_drive, o_state_comparator_en;
    logic o_fault_detect_en, o_fast_test_mode;
    ppmc_mode_t o_mode;
    int n_fail = 0;
    int comparisons = 0;
    always #5 i_clk = ~i_clk;
    ppmc_power_mode_control #(.HOLDOFF_CYC(HO), .DEG_FULL_CYC(20), .FAULT_DELAY_CYC(FD),
        .REC_DELAY_CYC(RD), .OC_REC_CYC(OCR), .TEST_ENTRY_CYC(TE)) uut (.*);
    ppmc_pack_model u_pack (.i_clk, .i_charge_fet_drive(o_charge_fet_drive),
        .i_discharge_fet_drive(o_discharge_fet_drive), .i_load_dir(load_dir),
        .o_charge_current_seen(i_charge_current_seen),
        .o_discharge_current_seen(i_discharge_current_seen));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc
    // bounded wait; a timeout shows up as a mode mismatch
    task automatic wait_mode(input ppmc_mode_t m, input int lim, output int n);
        n = 0;
        while (o_mode !== m && n < lim) begin
            @(posedge i_clk);
            n++;
        end
        check(o_mode, m);
    endtask : wait_mode
    function automatic logic [1:0] drv();
        return {o_charge_fet_drive, o_discharge_fet_drive};
    endfunction : drv
    task automatic set_fault(input int k, input logic v);
        case (k)
            0: i_chg_fault_raw <= v;
            1: i_dsg_fault_raw <= v;
            2: i_oc_fault_raw <= v;
            3: i_thermistor_ratio_bp <= v ? 14'h0B79 : 14'h1388;
            default: {i_ov_detect, i_cell_above_ov_hys} <= {v, v};
        endcase
    endtask : set_fault
    ////////////////////////////////////////////////////////////
    task automatic t_power_up();
        int n;
        cyc(20);
        check(o_mode, PPMC_WAIT_WAKE);
        i_supply_above_wake <= 1'b1;
        wait_mode(PPMC_HOLDOFF, 5, n);
        for (n = 0; o_mode === PPMC_HOLDOFF && n < 200; n++) begin
            check(drv(), 2'h0);
            @(posedge i_clk);
        end
        check(n >= HO - 1, 1'b1);
        wait_mode(PPMC_FAULT, 5, n);
        cyc(2);
        check(drv(), 2'h1);
        check(o_state_comparator_en, 1'b1);
        wait_mode(PPMC_NORMAL, 3 * RD + 20, n);
        check(n >= 3 * RD - 5, 1'b1);
        cyc(2);
        check(drv(), 2'h3);
        check(o_state_comparator_en, 1'b0);
    endtask : t_power_up
    task automatic t_ov_band();
        int n;
        i_reset_n <= 1'b0;
        i_cell_above_ov_hys <= 1'b1;
        cyc(3);
        i_reset_n <= 1'b1;
        wait_mode(PPMC_FAULT, HO + 40, n);
        cyc(200);
        check(o_charge_fet_drive, 1'b0);
        i_cell_above_ov_hys <= 1'b0;
        wait_mode(PPMC_NORMAL, 3 * RD + 10, n);
        cyc(2);
        check(drv(), 2'h3);
    endtask : t_ov_band
    task automatic t_faults();
        logic [1:0] exp [5] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h1};
        int n;
        i_thermistor_ratio_bp <= 14'h0B7A;
        cyc(3 * FD + 10);
        check(o_mode, PPMC_NORMAL);
        for (int k = 0; k < 5; k++) begin
            set_fault(k, 1'b1);
            cyc(3 * FD - 3);
            check(o_mode, PPMC_NORMAL);
            wait_mode(PPMC_FAULT, 3 * FD + 6, n);
            cyc(2);
            check(drv(), exp[k]);
            check(o_state_comparator_en, 1'b1);
            load_dir <= exp[k][1] ? 2'h1 : 2'h2;
            cyc(4);
            check(drv(), 2'h3);
            load_dir <= 2'h0;
            set_fault(k, 1'b0);
            wait_mode(PPMC_NORMAL, 3 * OCR + 10, n);
            cyc(2);
            check(drv(), 2'h3);
        end
    endtask : t_faults
    task automatic t_override();
        for (int k = 0; k < 2; k++) begin
            {i_charge_override_in, i_discharge_override_in} <= k ? 2'h2 : 2'h1;
            cyc(10);
            check(drv(), 2'h3);
            cyc(15);
            check(drv(), k ? 2'h2 : 2'h1);
            {i_charge_override_in, i_discharge_override_in} <= 2'h3;
            cyc(10);
            check(drv(), k ? 2'h2 : 2'h1);
            cyc(15);
            check(drv(), 2'h3);
        end
    endtask : t_override
    task automatic t_test_mode();
        int n;
        i_supply_above_test_margin <= 1'b1;
        cyc(TE - 3);
        check(o_fast_test_mode, 1'b0);
        cyc(6);
        check(o_fast_test_mode, 1'b1);
        i_supply_above_test_margin <= 1'b0;
        i_chg_fault_raw <= 1'b1;
        cyc(TD - 20);
        check(o_mode, PPMC_NORMAL);
        wait_mode(PPMC_FAULT, 40, n);
        i_chg_fault_raw <= 1'b0;
        wait_mode(PPMC_NORMAL, TD + 20, n);
        i_supply_at_top_cell <= 1'b1;
        cyc(TE + 3);
        check(o_fast_test_mode, 1'b0);
        i_supply_at_top_cell <= 1'b0;
        i_chg_fault_raw <= 1'b1;
        wait_mode(PPMC_FAULT, 3 * FD + 6, n);
        i_chg_fault_raw <= 1'b0;
        wait_mode(PPMC_NORMAL, 3 * RD + 10, n);
    endtask : t_test_mode
    task automatic t_shutdown();
        int n;
        i_supply_below_shut <= 1'b1;
        i_supply_above_wake <= 1'b0;
        wait_mode(PPMC_SHUTDOWN, 5, n);
        cyc(2);
        check(drv(), 2'h0);
        check(o_fault_detect_en, 1'b0);
        i_chg_fault_raw <= 1'b1;
        i_supply_below_shut <= 1'b0;
        cyc(3 * FD + 10);
        check(o_mode, PPMC_SHUTDOWN);
        i_chg_fault_raw <= 1'b0;
        i_supply_above_wake <= 1'b1;
        wait_mode(PPMC_NORMAL, 5, n);
        cyc(2);
        check(drv(), 2'h3);
    endtask : t_shutdown
    ////////////////////////////////////////////////////////////
    initial begin
        {i_reset_n, i_supply_above_wake, i_supply_below_shut, i_supply_at_top_cell} = 4'h0;
        {i_supply_above_test_margin, i_ov_detect, i_cell_above_ov_hys} = 3'h0;
        {i_chg_fault_raw, i_dsg_fault_raw, i_oc_fault_raw, load_dir} = 5'h00;
        i_thermistor_ratio_bp = 14'h1388;
        // single protector, no upper device feeding the overrides
        {i_charge_override_in, i_discharge_override_in} = 2'h3;
        cyc(12);
        i_reset_n <= 1'b1;
        t_power_up();
        t_ov_band();
        t_faults();
        t_override();
        t_test_mode();
        t_shutdown();
        conclude();
    end
    // about 3000 cycles expected; nearly seven times that is a hang
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
endmodule : testbench
